/* verilog/sfs_pkg.sv */
// sfs_pkg: opcodes, lane widths, phase lengths and timing for the flash command sequencer
// assumes one 250 MHz system clock; the spi clock is oversampled, not used as a clock
`default_nettype none
package sfs_pkg;

	// command opcodes handled by this block
	localparam logic [7:0] OP_FAST_READ  = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO    = 8'heb;
	localparam logic [7:0] OP_PAGE_PROG  = 8'h02;

	// lanes used per clock
	localparam logic [2:0] LANES_ONE     = 3'h1;
	localparam logic [2:0] LANES_TWO     = 3'h2;
	localparam logic [2:0] LANES_FOUR    = 3'h4;

	// phase lengths in spi clocks
	localparam logic [4:0] OPCODE_CLOCKS = 5'h08;
	localparam logic [4:0] DUMMY_FAST    = 5'h08;
	localparam logic [4:0] DUMMY_NONE    = 5'h00;
	localparam logic [4:0] DUMMY_QUAD_IO = 5'h04;

	// array geometry
	localparam int         ADDR_BITS     = 24;
	localparam int         PAGE_BYTES    = 256;

	// pin group reset value: chip select idle high, clock and lanes low
	localparam logic [5:0] PIN_IDLE      = 6'h20;

	// program cycle time
	localparam int         CLOCK_PERIOD_PS = 4000;
	localparam int         PROG_TIME_NS    = 400000;
	localparam int         PROG_CYCLES     = PROG_TIME_NS * 1000 / CLOCK_PERIOD_PS;

endpackage : sfs_pkg
`default_nettype wire

/* verilog/sfs_pin_sync.sv */
// sfs_pin_sync: three-stage synchroniser for asynchronous pins with an agreement filter
// assumes pins may change at any time relative to clock
`timescale 1ns/1ps
`default_nettype none
module sfs_pin_sync #(
	parameter int               WIDTH = 6,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 feeds only stage2, so metastability never reaches the filter
	always_ff @(posedge clock) begin
		if (!rstn) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit changes only once stage2 and stage3 agree
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pinOut <= INIT;
		end else begin
			pinOut <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & pinOut);
		end
	end

endmodule : sfs_pin_sync
`default_nettype wire

/* verilog/sfs_flash_seq.sv */
// sfs_flash_seq: fast read family and page program command handling of a serial nor flash
// assumes array read data follows memReadAddr within one clock, array writes and-in data,
// and protection decode, status reads and the write enable commands live outside
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_seq
	import sfs_pkg::*;
#(
	parameter int PROG_CYCLE_COUNT = PROG_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        sclkPin,
	input  wire logic        chipSelectN,
	input  wire logic [3:0]  laneIn,
	output logic      [3:0]  laneOut,
	output logic      [3:0]  laneOe,
	input  wire logic        quadLaneEnableBit,
	input  wire logic        writeLatchArmed,
	output logic             clearWriteLatch,
	output logic             busyFlag,
	output logic      [23:0] memReadAddr,
	input  wire logic [7:0]  memReadData,
	output logic             arrayWriteStrobe,
	output logic      [23:0] arrayWriteAddr,
	output logic      [7:0]  arrayWriteData,
	output logic      [15:0] progPageAddr,
	input  wire logic        progPageLocked,
	output logic      [7:0]  continuousReadModeBits
);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR   = 3'b010,
		ST_MODE   = 3'b011,
		ST_DUMMY  = 3'b100,
		ST_READ   = 3'b101,
		ST_PROG   = 3'b110,
		ST_IGNORE = 3'b111
	} sfs_state_t;

	typedef enum logic [1:0] {
		PG_IDLE  = 2'b00,
		PG_CHECK = 2'b01,
		PG_WRITE = 2'b10,
		PG_WAIT  = 2'b11
	} sfs_prog_t;

	sfs_state_t             state;
	sfs_prog_t              pgState;
	logic [5:0]             pinsF;
	logic                   sclkF;
	logic                   csnF;
	logic [3:0]             lanesF;
	logic                   sclkPrev;
	logic                   csnPrev;
	logic                   riseEv;
	logic                   fallEv;
	logic                   csnRise;
	logic                   csnFall;
	logic [4:0]             clkCnt;
	logic [23:0]            inShift;
	logic [23:0]            next_shift;
	logic [7:0]             opNow;
	logic [2:0]             addrW;
	logic [2:0]             dataW;
	logic [4:0]             dummyN;
	logic                   hasMode;
	logic [7:0]             txByte;
	logic [2:0]             beat;
	logic [6:0]             progByte;
	logic [2:0]             progBitCnt;
	logic [23:0]            progAddr;
	logic [7:0]             progIdx;
	logic                   progAny;
	logic                   progStart;
	logic                   byteStrobe;
	logic                   clearStrobe;
	logic [7:0]             pageBuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0]  pageValid;
	logic [7:0]             walkIdx;
	logic [31:0]            pgTimer;
	logic                   progCmd;
	logic [4:0]             beatsPerByte;

	// shift lanes into the low end, lane three first in quad, lane one first in dual
	function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] lanes, input logic [2:0] w);
		case (w)
			LANES_FOUR: shiftIn = {sh[19:0], lanes};
			LANES_TWO:  shiftIn = {sh[21:0], lanes[1:0]};
			default:    shiftIn = {sh[22:0], lanes[0]};
		endcase
	endfunction : shiftIn

	// spi clocks needed to move nbits over w lanes
	function automatic logic [4:0] phaseClocks(input logic [4:0] nbits, input logic [2:0] w);
		case (w)
			LANES_FOUR: phaseClocks = {2'h0, nbits[4:2]};
			LANES_TWO:  phaseClocks = {1'h0, nbits[4:1]};
			default:    phaseClocks = nbits;
		endcase
	endfunction : phaseClocks

	// lane values for one beat of a byte; single lane data leaves on lane one
	function automatic logic [3:0] laneSlice(input logic [7:0] b, input logic [2:0] pos, input logic [2:0] w);
		logic [7:0] rot;
		rot = b << (pos * w);
		case (w)
			LANES_FOUR: laneSlice = rot[7:4];
			LANES_TWO:  laneSlice = {2'h0, rot[7:6]};
			default:    laneSlice = {2'h0, rot[7], 1'h0};
		endcase
	endfunction : laneSlice

	// chip select, spi clock and the four lanes all cross from the pins
	sfs_pin_sync #(
		.WIDTH (6),
		.INIT  (PIN_IDLE)
	) pinSync (
		.clock  (clock),
		.rstn   (rstn),
		.pinIn  ({chipSelectN, sclkPin, laneIn}),
		.pinOut (pinsF)
	);

	assign csnF   = pinsF[5];
	assign sclkF  = pinsF[4];
	assign lanesF = pinsF[3:0];

	// edge detection on the filtered pins
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sclkPrev <= 1'b0;
			csnPrev  <= 1'b1;
		end else begin
			sclkPrev <= sclkF;
			csnPrev  <= csnF;
		end
	end

	assign riseEv     = sclkF & ~sclkPrev & ~csnF;
	assign fallEv     = ~sclkF & sclkPrev & ~csnF;
	assign csnRise    = csnF & ~csnPrev;
	assign csnFall    = ~csnF & csnPrev;
	assign opNow      = {inShift[6:0], lanesF[0]};
	assign next_shift = shiftIn(inShift, lanesF, addrW);
	assign beatsPerByte = phaseClocks(5'd8, dataW);
	assign byteStrobe = riseEv && state == ST_PROG && progBitCnt == 3'h7;
	assign clearStrobe = riseEv && state == ST_OPCODE && clkCnt == OPCODE_CLOCKS - 5'h01
		&& opNow == OP_PAGE_PROG && writeLatchArmed && !busyFlag;
	// discard unless the last byte completed exactly at deselect
	assign progStart  = csnRise && state == ST_PROG && progBitCnt == 3'h0 && progAny;

	// command sequencer, advanced on rising spi clock edges
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state   <= ST_IDLE;
			clkCnt  <= 5'h00;
			inShift <= 24'h000000;
			addrW   <= LANES_ONE;
			dataW   <= LANES_ONE;
			dummyN  <= DUMMY_FAST;
			hasMode <= 1'b0;
			continuousReadModeBits <= 8'h00;
		end else if (csnF) begin
			state  <= ST_IDLE;
			clkCnt <= 5'h00;
		end else if (csnFall) begin
			state   <= ST_OPCODE;
			clkCnt  <= 5'h00;
			inShift <= 24'h000000;
		end else if (riseEv) begin
			clkCnt <= clkCnt + 5'h01;
			case (state)
				ST_OPCODE: begin
					inShift <= {inShift[22:0], lanesF[0]};
					if (clkCnt == OPCODE_CLOCKS - 5'h01) begin
						clkCnt  <= 5'h00;
						hasMode <= 1'b0;
						dummyN  <= DUMMY_FAST;
						addrW   <= LANES_ONE;
						dataW   <= LANES_ONE;
						state   <= ST_ADDR;
						// nothing but status polling is served while a cycle runs
						if (busyFlag) state <= ST_IGNORE;
						else case (opNow)
							OP_FAST_READ: dataW <= LANES_ONE;
							OP_DUAL_OUT:  dataW <= LANES_TWO;
							OP_QUAD_OUT: begin
								dataW <= LANES_FOUR;
								if (!quadLaneEnableBit) state <= ST_IGNORE;
							end
							OP_DUAL_IO: begin
								addrW   <= LANES_TWO;
								dataW   <= LANES_TWO;
								hasMode <= 1'b1;
								dummyN  <= DUMMY_NONE;
							end
							OP_QUAD_IO: begin
								addrW   <= LANES_FOUR;
								dataW   <= LANES_FOUR;
								hasMode <= 1'b1;
								dummyN  <= DUMMY_QUAD_IO;
								if (!quadLaneEnableBit) state <= ST_IGNORE;
							end
							OP_PAGE_PROG: begin
								if (!writeLatchArmed) state <= ST_IGNORE;
							end
							default: state <= ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					inShift <= next_shift;
					if (clkCnt == phaseClocks(5'd24, addrW) - 5'h01) begin
						clkCnt <= 5'h00;
						// the accept mark decides, the shifter now holds address bits, not the opcode
						if (progCmd) state <= ST_PROG;
						else if (hasMode) state <= ST_MODE;
						else state <= ST_DUMMY;
					end
				end
				ST_MODE: begin
					// in dual io these four mode clocks are the dummy clocks
					inShift <= next_shift;
					if (clkCnt == phaseClocks(5'd8, addrW) - 5'h01) begin
						clkCnt <= 5'h00;
						continuousReadModeBits <= next_shift[7:0];
						state  <= (dummyN == DUMMY_NONE) ? ST_READ : ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					if (clkCnt == dummyN - 5'h01) begin
						clkCnt <= 5'h00;
						state  <= ST_READ;
					end
				end
				default: clkCnt <= 5'h00;
			endcase
		end
	end

	// a program command is marked when 02h is accepted, cleared on deselect
	always_ff @(posedge clock) begin
		if (!rstn) progCmd <= 1'b0;
		else if (csnF) progCmd <= 1'b0;
		else if (clearStrobe) progCmd <= 1'b1;
	end

	// read address: loaded at the end of address, stepped once per byte sent
	always_ff @(posedge clock) begin
		if (!rstn) begin
			memReadAddr <= 24'h000000;
			progAddr    <= 24'h000000;
		end else if (riseEv && state == ST_ADDR && clkCnt == phaseClocks(5'd24, addrW) - 5'h01) begin
			memReadAddr <= next_shift;
			progAddr    <= next_shift;
		end else if (fallEv && state == ST_READ && beat == 3'h0) begin
			memReadAddr <= memReadAddr + 24'h000001;
		end
	end

	// lane drive: changes on falling spi clock, released on deselect and outside data
	always_ff @(posedge clock) begin
		if (!rstn) begin
			laneOut <= 4'h0;
			laneOe  <= 4'h0;
			txByte  <= 8'h00;
			beat    <= 3'h0;
		end else if (csnF || state != ST_READ) begin
			laneOe <= 4'h0;
			beat   <= 3'h0;
		end else if (fallEv) begin
			if (beat == 3'h0) begin
				txByte  <= memReadData;
				laneOut <= laneSlice(memReadData, 3'h0, dataW);
			end else begin
				laneOut <= laneSlice(txByte, beat, dataW);
			end
			case (dataW)
				LANES_FOUR: laneOe <= 4'hf;
				LANES_TWO:  laneOe <= 4'h3;
				default:    laneOe <= 4'h2;
			endcase
			beat <= (beat == beatsPerByte[2:0] - 3'h1) ? 3'h0 : beat + 3'h1;
		end
	end

	// program data collection on lane zero, byte index wraps inside the page
	always_ff @(posedge clock) begin
		if (!rstn) begin
			progByte   <= 7'h00;
			progBitCnt <= 3'h0;
			progIdx    <= 8'h00;
			progAny    <= 1'b0;
		end else if (csnFall) begin
			progBitCnt <= 3'h0;
			progAny    <= 1'b0;
		end else if (riseEv && state == ST_ADDR) begin
			progIdx <= next_shift[7:0];
		end else if (riseEv && state == ST_PROG) begin
			progByte   <= {progByte[5:0], lanesF[0]};
			progBitCnt <= progBitCnt + 3'h1;
			if (byteStrobe) begin
				progIdx <= progIdx + 8'h01;
				progAny <= 1'b1;
			end
		end
	end

	// page buffer: later bytes at the same index overwrite earlier ones
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pageValid <= '0;
		end else if (clearStrobe) begin
			pageValid <= '0;
		end else if (byteStrobe) begin
			pageValid[progIdx] <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (byteStrobe) pageBuf[progIdx] <= {progByte, lanesF[0]};
	end

	// program engine: protection check, buffer walk, then wait out the cycle time
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pgState          <= PG_IDLE;
			busyFlag         <= 1'b0;
			clearWriteLatch  <= 1'b0;
			walkIdx          <= 8'h00;
			pgTimer          <= 32'h00000000;
			progPageAddr     <= 16'h0000;
			arrayWriteStrobe <= 1'b0;
			arrayWriteAddr   <= 24'h000000;
			arrayWriteData   <= 8'h00;
		end else begin
			clearWriteLatch  <= 1'b0;
			arrayWriteStrobe <= 1'b0;
			case (pgState)
				PG_IDLE: begin
					if (progStart) begin
						progPageAddr <= progAddr[23:8];
						pgState      <= PG_CHECK;
					end
				end
				PG_CHECK: begin
					walkIdx <= 8'h00;
					pgTimer <= 32'h00000000;
					if (progPageLocked) pgState <= PG_IDLE;
					else begin
						busyFlag <= 1'b1;
						pgState  <= PG_WRITE;
					end
				end
				PG_WRITE: begin
					pgTimer          <= pgTimer + 32'h00000001;
					arrayWriteStrobe <= pageValid[walkIdx];
					arrayWriteAddr   <= {progPageAddr, walkIdx};
					arrayWriteData   <= pageBuf[walkIdx];
					walkIdx          <= walkIdx + 8'h01;
					if (walkIdx == 8'hff) pgState <= PG_WAIT;
				end
				PG_WAIT: begin
					pgTimer <= pgTimer + 32'h00000001;
					if (pgTimer >= 32'(PROG_CYCLE_COUNT - 1)) begin
						busyFlag        <= 1'b0;
						clearWriteLatch <= 1'b1;
						pgState         <= PG_IDLE;
					end
				end
				default: pgState <= PG_IDLE;
			endcase
		end
	end

endmodule : sfs_flash_seq
`default_nettype wire

/* sim/sfs_flash_seq_props.sv */
// sfs_flash_seq_props: port-level checks of the flash command sequencer
// assumes quad enable and the write latch only change while chip select is high
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_seq_props #(
	parameter int PROG_CYCLE_COUNT = 300
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        chipSelectN,
	input wire logic [3:0]  laneOe,
	input wire logic        quadLaneEnableBit,
	input wire logic        writeLatchArmed,
	input wire logic        clearWriteLatch,
	input wire logic        busyFlag,
	input wire logic        arrayWriteStrobe,
	input wire logic [23:0] arrayWriteAddr,
	input wire logic [15:0] progPageAddr,
	input wire logic        progPageLocked
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// busy length; slack of two absorbs the walk start handover
	int busyLen;
	always_ff @(posedge clock) begin
		if (!rstn || !busyFlag) begin
			busyLen <= 0;
		end else begin
			busyLen <= busyLen + 1;
		end
	end
	property p_idle_quiet; chipSelectN [*8] |-> laneOe == 4'h0; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("lanes driven while deselected");
	property p_oe_shape; laneOe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
	a_oe_shape: assert property (p_oe_shape) else $error("bad lane enable pattern");
	property p_quad_gate; laneOe == 4'hf |-> quadLaneEnableBit; endproperty
	a_quad_gate: assert property (p_quad_gate) else $error("quad drive without enable");
	property p_busy_quiet; busyFlag |-> laneOe == 4'h0; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("read served while busy");
	property p_prog_gate; $rose(busyFlag) |-> writeLatchArmed && !progPageLocked; endproperty
	a_prog_gate: assert property (p_prog_gate) else $error("program started unarmed or locked");
	property p_busy_after_cs; $rose(busyFlag) |-> $past(chipSelectN, 2); endproperty
	a_busy_after_cs: assert property (p_busy_after_cs) else $error("busy before deselect");
	property p_busy_len; $fell(busyFlag) |-> busyLen >= PROG_CYCLE_COUNT - 2 && busyLen <= PROG_CYCLE_COUNT + 2; endproperty
	a_busy_len: assert property (p_busy_len) else $error("program time wrong");
	property p_clear_end; $fell(busyFlag) |-> ##[0:1] clearWriteLatch; endproperty
	a_clear_end: assert property (p_clear_end) else $error("latch not cleared at end");
	property p_clear_pulse; clearWriteLatch |=> !clearWriteLatch && !busyFlag; endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("latch clear not a pulse");
	property p_write_busy; arrayWriteStrobe |-> busyFlag; endproperty
	a_write_busy: assert property (p_write_busy) else $error("write outside program cycle");
	property p_write_page; arrayWriteStrobe |-> arrayWriteAddr[23:8] == progPageAddr; endproperty
	a_write_page: assert property (p_write_page) else $error("write left the page");
endmodule : sfs_flash_seq_props
`default_nettype wire

/* sim/sfs_host_model.sv */
// sfs_host_model: spi host driving chip select, clock and lanes (mode 0)
// assumes the bench resolves each lane wire and feeds it back on laneWire
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model #(
	parameter int HALF = 8
) (
	input  wire logic       clock,
	input  wire logic [3:0] laneWire,
	output logic            sclkPin,
	output logic            chipSelectN,
	output logic      [3:0] hostOut,
	output logic      [3:0] hostOe
);
	initial begin
		sclkPin = 1'b0;
		chipSelectN = 1'b1;
		hostOut = 4'h0;
		hostOe = 4'h0;
	end
	// one spi clock: lanes change while low, sampled at the end of the low half
	task automatic spiClock(input logic [3:0] oe, input logic [3:0] d, output logic [3:0] q);
		sclkPin <= 1'b0;
		hostOe <= oe;
		hostOut <= d;
		repeat (HALF) @(posedge clock);
		q = laneWire;
		sclkPin <= 1'b1;
		repeat (HALF) @(posedge clock);
	endtask : spiClock
	// msb first over w lanes; receiving releases every lane
	task automatic xfer(input logic [31:0] v, input int nbits, input int w, input logic drive,
		output logic [31:0] r);
		logic [3:0] q;
		logic [3:0] m;
		m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : 4'h1;
		r = 32'h0;
		if (!drive) begin
			hostOe <= 4'h0; // lanes let go one clock ahead of the first data fall
			@(posedge clock);
		end
		for (int i = nbits - w; i >= 0; i -= w) begin
			spiClock(drive ? m : 4'h0, 4'(v >> i) & m, q);
			if (!drive && w == 1) begin
				q = q >> 1;
			end
			r = (r << w) | 32'(q & m);
		end
	endtask : xfer
	task automatic select();
		chipSelectN <= 1'b0;
		repeat (HALF) @(posedge clock);
	endtask : select
	// deselect only after the clock has gone low, wherever the bit count stands
	task automatic deselect();
		sclkPin <= 1'b0;
		hostOe <= 4'h0;
		repeat (HALF) @(posedge clock);
		chipSelectN <= 1'b1;
		repeat (4 * HALF) @(posedge clock);
	endtask : deselect
endmodule : sfs_host_model
`default_nettype wire

/* sim/tb.sv */
// tb: self-checking bench for the flash command sequencer
// assumes a 250 MHz clock and a shortened program time
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfs_pkg::*;
	localparam int PCC = 300;
	localparam int LIMIT = 80000;
	logic clock, rstn, sclkPin, chipSelectN, quadEn, latchArmed, clearWriteLatch, busyFlag;
	logic arrayWriteStrobe, progPageLocked, floatBit;
	logic [3:0] hostOut, hostOe, laneWire, laneOut, laneOe;
	logic [23:0] memReadAddr, arrayWriteAddr;
	logic [7:0] memReadData, arrayWriteData, modeBits;
	logic [15:0] progPageAddr, lockPage;
	logic [7:0] wrData [0:255];
	int wrCount, busyCycles, oeCycles, cyc, badCount, testsRun;
	// released lanes toggle so a stale level never passes for data
	assign laneWire = (laneOe & laneOut) | (~laneOe & hostOe & hostOut) | (~laneOe & ~hostOe & {4{floatBit}});
	// array and protection stand-ins
	assign memReadData = memReadAddr[7:0] ^ memReadAddr[15:8];
	assign progPageLocked = (progPageAddr === lockPage);
	sfs_host_model host (.clock(clock), .laneWire(laneWire), .sclkPin(sclkPin), .chipSelectN(chipSelectN),
		.hostOut(hostOut), .hostOe(hostOe));
	sfs_flash_seq #(.PROG_CYCLE_COUNT(PCC)) DUT (.clock(clock), .rstn(rstn), .sclkPin(sclkPin),
		.chipSelectN(chipSelectN), .laneIn(laneWire), .laneOut(laneOut), .laneOe(laneOe),
		.quadLaneEnableBit(quadEn), .writeLatchArmed(latchArmed), .clearWriteLatch(clearWriteLatch),
		.busyFlag(busyFlag), .memReadAddr(memReadAddr), .memReadData(memReadData),
		.arrayWriteStrobe(arrayWriteStrobe), .arrayWriteAddr(arrayWriteAddr), .arrayWriteData(arrayWriteData),
		.progPageAddr(progPageAddr), .progPageLocked(progPageLocked), .continuousReadModeBits(modeBits));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// activity counters, write log, latch model and hang guard
	always @(posedge clock) begin
		floatBit <= ~floatBit;
		cyc <= cyc + 1;
		if (busyFlag === 1'b1) busyCycles <= busyCycles + 1;
		if (|laneOe) oeCycles <= oeCycles + 1;
		if (clearWriteLatch === 1'b1) latchArmed <= 1'b0;
		if (arrayWriteStrobe === 1'b1) begin
			wrData[arrayWriteAddr[7:0]] <= arrayWriteData;
			wrCount <= wrCount + 1;
		end
		if (cyc == LIMIT) begin
			badCount++;
			endSim();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic endSim();
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : endSim
	// starts at the last byte of a page, so the address must step across it
	task automatic readCase(input logic [7:0] op, input int aw, input int dw, input int modeOn,
		input int dummy, input logic ok);
		logic [31:0] r;
		int oe0;
		oe0 = oeCycles;
		host.select();
		host.xfer(32'(op), 8, 1, 1'b1, r);
		host.xfer(32'h1234ff, 24, aw, 1'b1, r);
		if (modeOn != 0) begin
			host.xfer(32'hf5, 8, aw, 1'b1, r); // upper nibble all ones
		end
		host.xfer(32'h0, dummy, 1, 1'b0, r);
		host.xfer(32'h0, 16, dw, 1'b0, r);
		host.deselect();
		if (ok) begin
			check("read data", r, 32'h0000cb35);
			if (modeOn != 0) begin
				check("mode bits", 32'(modeBits), 32'hf5);
			end
		end else begin
			check("refused lanes", 32'(oeCycles - oe0), 32'h0);
		end
	endtask : readCase
	// byte k carries k^33h and lands at page index a+k
	task automatic prog(input logic [23:0] a, input int n, input int extra, input logic armed, input logic ok);
		logic [31:0] r;
		int w0;
		int b0;
		int k;
		latchArmed <= armed;
		w0 = wrCount;
		b0 = busyCycles;
		host.select();
		host.xfer(32'h02, 8, 1, 1'b1, r);
		host.xfer(32'(a), 24, 1, 1'b1, r);
		for (k = 0; k < n; k++) begin
			host.xfer(32'(k[7:0] ^ 8'h33), 8, 1, 1'b1, r);
		end
		host.xfer(32'h0, extra, 1, 1'b1, r);
		host.deselect();
		for (k = 0; k < 400 && busyFlag !== 1'b0; k++) begin
			@(posedge clock);
		end
		// one more edge so the latch model has taken the clear pulse
		@(posedge clock);
		check("busy end", 32'(busyFlag), 32'h0);
		check("busy length", 32'(busyCycles - b0), ok ? 32'(PCC) : 32'h0);
		check("latch", 32'(latchArmed), 32'(armed & ~ok));
		check("writes", 32'(wrCount - w0), ok ? 32'(n > 256 ? 256 : n) : 32'h0);
		if (ok) begin
			check("page addr", 32'(progPageAddr), 32'(a[23:8]));
		end
		for (k = (n > 256 ? n - 256 : 0); ok && k < n; k++) begin
			check("page byte", 32'(wrData[a[7:0] + 8'(k)]), 32'(k[7:0] ^ 8'h33));
		end
	endtask : prog
	initial begin
		rstn = 1'b0;
		quadEn = 1'b1;
		latchArmed = 1'b0;
		lockPage = 16'h0a11;
		floatBit = 1'b0;
		{wrCount, busyCycles, oeCycles, cyc, badCount, testsRun} = '0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		repeat (8) @(posedge clock);
		readCase(OP_FAST_READ, 1, 1, 0, 8, 1'b1);
		readCase(OP_DUAL_OUT, 1, 2, 0, 8, 1'b1);
		readCase(OP_QUAD_OUT, 1, 4, 0, 8, 1'b1);
		readCase(OP_DUAL_IO, 2, 2, 1, 0, 1'b1);
		readCase(OP_QUAD_IO, 4, 4, 1, 4, 1'b1);
		quadEn <= 1'b0;
		@(posedge clock);
		readCase(OP_QUAD_OUT, 1, 4, 0, 8, 1'b0);
		readCase(OP_QUAD_IO, 4, 4, 1, 4, 1'b0);
		prog(24'h0a10fe, 3, 0, 1'b1, 1'b1);
		prog(24'h0a1000, 258, 0, 1'b1, 1'b1);
		prog(24'h0a1000, 1, 0, 1'b0, 1'b0);
		prog(24'h0a1100, 1, 0, 1'b1, 1'b0);
		prog(24'h0a1000, 1, 3, 1'b1, 1'b0);
		endSim();
	end
endmodule : tb
bind sfs_flash_seq sfs_flash_seq_props #(.PROG_CYCLE_COUNT(PROG_CYCLE_COUNT)) props (.clock(clock), .rstn(rstn),
	.chipSelectN(chipSelectN), .laneOe(laneOe), .quadLaneEnableBit(quadLaneEnableBit),
	.writeLatchArmed(writeLatchArmed), .clearWriteLatch(clearWriteLatch), .busyFlag(busyFlag),
	.arrayWriteStrobe(arrayWriteStrobe), .arrayWriteAddr(arrayWriteAddr), .progPageAddr(progPageAddr),
	.progPageLocked(progPageLocked));
`default_nettype wire
